// [fram_guard_pkg.sv]
// Behaviour
// - Write enable latch is clear after reset; no write accepted until set.
// - Set-latch command sets the latch; status bit shows it.
// - Status write never sets the latch flag; only set-latch sets it.
// - Chip-select rise after clear-latch, status write or memory write clears latch.
// - Clear-latch command clears the latch; status then reads latch flag 0.
// - Write-protect pin low refuses all memory and status writes.
// - Status bits 0 and 4-7 are unwritable and read zero.
// - Status bit 1 reports the latch, 1 meaning writes enabled.
// - Block guard bits live at status bits 2 (low) and 3 (high).
// - Guard 00 none, 01 180h-1FFh, 10 100h-1FFh, 11 whole array.
// - Writes need latch set and pin high; guarded blocks always refuse.
// - After status-read opcode, device shifts out the status byte.
// - Status write updates guard bits only with latch set and pin high.
// - Write opcode bit 3 is A8; next byte is A7-A0.
// - Further data bytes go to successive addresses; 1FFh wraps to 000h.
// - Data bytes arrive most significant bit first.
// - Chip-select rise ends a memory write.
// - Burst reaching a guarded address stops incrementing, drops remaining bytes.
// - Each byte is committed once its eighth bit arrives.
// - A byte cut off by chip-select rise is dropped.
// - Opcodes 06 set, 04 clear, 05 status read, 01 status write, 0000A010 write.
// - First byte after chip-select fall is the opcode; one per frame.
// - Input sampled on serial clock rise, output shifted on fall.
// - Unknown opcode ignored with all input until next frame; output off.
package fram_guard_pkg;

  localparam int ADDR_W    = 9;
  localparam int DATA_W    = 8;
  localparam int MEM_DEPTH = 512;

  localparam logic [7:0] OP_SET_LATCH   = 8'h06;
  localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_RD   = 8'h05;
  localparam logic [7:0] OP_STATUS_WR   = 8'h01;
  localparam logic [2:0] OP_WRITE_LOW   = 3'h2;
  localparam int         OP_A8_POS      = 3;

  localparam int SR_LATCH_POS = 1;
  localparam int SR_GUARD_LO  = 2;
  localparam int SR_GUARD_HI  = 3;

  localparam logic       LATCH_RESET = 1'h0;
  localparam logic [1:0] GUARD_RESET = 2'h0;
  localparam logic [8:0] GUARD_QUARTER = 9'h180;
  localparam logic [8:0] GUARD_HALF    = 9'h100;

  typedef enum logic [2:0] {S_IDLE, S_OPCODE, S_ADDR, S_WDATA, S_STWR, S_STRD, S_SKIP}
    cmd_state_t;

  function automatic logic isGuarded(input logic [1:0] guard, input logic [8:0] addr);
    unique case (guard)
      2'h0: isGuarded = 1'b0;
      2'h1: isGuarded = addr >= GUARD_QUARTER;
      2'h2: isGuarded = addr >= GUARD_HALF;
      2'h3: isGuarded = 1'b1;
    endcase
  endfunction

  function automatic logic [7:0] statusByte(input logic latch, input logic [1:0] guard);
    statusByte = 8'h00;
    statusByte[SR_LATCH_POS] = latch;
    statusByte[SR_GUARD_HI:SR_GUARD_LO] = guard;
  endfunction

  function automatic logic isWriteOp(input logic [7:0] op);
    isWriteOp = (op[7:4] == 4'h0) && (op[2:0] == OP_WRITE_LOW);
  endfunction

endpackage

// [mem_wr_if.sv]
`timescale 1ns/10ps
interface mem_wr_if;
  logic       valid;
  logic       ready;
  logic [8:0] addr;
  logic [7:0] data;

  modport src (output valid, output addr, output data, input ready);
  modport snk (input valid, input addr, input data, output ready);
endinterface

// [wr_buffer.sv]
`timescale 1ns/10ps
module wr_buffer
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Fill and drain sides
  mem_wr_if.snk     fill,
  mem_wr_if.src     drain
);
  import fram_guard_pkg::*;

  typedef struct packed {
    logic [1:0][16:0] slot;
    logic             wrPtr;
    logic             rdPtr;
    logic [1:0]       count;
  } buf_t;

  buf_t q;
  buf_t n;

  logic pushOk;
  logic popOk;

  assign pushOk      = fill.valid && (q.count != 2'h2);
  assign popOk       = (q.count != 2'h0) && drain.ready;
  assign fill.ready  = q.count != 2'h2;
  assign drain.valid = q.count != 2'h0;
  assign drain.addr  = q.slot[q.rdPtr][16:8];
  assign drain.data  = q.slot[q.rdPtr][7:0];

  always_comb
  begin
    n = q;
    if (pushOk)
    begin
      n.slot[q.wrPtr] = {fill.addr, fill.data};
      n.wrPtr = ~q.wrPtr;
    end
    if (popOk)
      n.rdPtr = ~q.rdPtr;
    n.count = q.count + {1'b0, pushOk} - {1'b0, popOk};
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      q <= '0;
    else
      q <= n;
  end
endmodule

// [fram_array.sv]
`timescale 1ns/10ps
module fram_array
(
  // Clock
  input  wire logic       mclk,
  // Write port
  mem_wr_if.snk           wr,
  // Read port for inspection
  input  wire logic [8:0] rdAddr,
  output logic      [7:0] rdData
);
  import fram_guard_pkg::*;

  logic [7:0] cells [MEM_DEPTH];

  // Ferroelectric cells take a byte every cycle; never stalls
  assign wr.ready = 1'b1;

  always_ff @(posedge mclk)
  begin
    if (wr.valid)
      cells[wr.addr] <= wr.data;
    rdData <= cells[rdAddr];
  end
endmodule

// [spi_fram_write_guard.sv]
`timescale 1ns/10ps
module spi_fram_write_guard
(
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst,
  // Serial pins
  input  wire logic                    csN,
  input  wire logic                    sck,
  input  wire logic                    si,
  input  wire logic                    wpN,
  output logic                         so,
  output logic                         soOe,
  // Observation
  output logic                         latchOn,
  output logic [1:0]                   guardBits,
  input  wire logic [fram_guard_pkg::ADDR_W-1:0] memRdAddr,
  output logic      [fram_guard_pkg::DATA_W-1:0] memRdData
);
  import fram_guard_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic       csM;
    logic       cs2;
    logic       cs3;
    logic       sckM;
    logic       sck2;
    logic       sck3;
    logic       siM;
    logic       si2;
    logic       wpM;
    logic       wp2;
    cmd_state_t state;
    logic [2:0] bitCnt;
    logic [7:0] inSh;
    logic [7:0] outSh;
    logic [8:0] addr;
    logic       stopped;
    logic       pendClr;
    logic       write_enable_latch;
    logic [1:0] bp;
    logic       so;
    logic       soOe;
    logic       pushValid;
    logic [8:0] pushAddr;
    logic [7:0] pushData;
  } guard_t;

  guard_t q;
  guard_t n;

  mem_wr_if pushIf ();
  mem_wr_if memIf ();

  logic       csLow;
  logic       csFall;
  logic       csRise;
  logic       sckRise;
  logic       sckFall;
  logic       wpHigh;
  logic [7:0] inByte;
  logic       byteDone;
  logic [7:0] txBits;
  logic       inFrame;

  assign csLow    = !q.cs2;
  assign csFall   = !q.cs2 && q.cs3;
  assign csRise   = q.cs2 && !q.cs3;
  assign sckRise  = q.sck2 && !q.sck3;
  assign sckFall  = !q.sck2 && q.sck3;
  assign wpHigh   = q.wp2;
  assign inByte   = {q.inSh[6:0], q.si2};
  assign byteDone = sckRise && (q.bitCnt == 3'h7);
  assign txBits   = (q.bitCnt == 3'h0) ? statusByte(q.write_enable_latch, q.bp) : q.outSh;
  assign inFrame  = csLow && !csFall;

  // ==========================================================
  // Command decoder
  always_comb
  begin
    n = q;
    n.csM  = csN;
    n.cs2  = q.csM;
    n.cs3  = q.cs2;
    n.sckM = sck;
    n.sck2 = q.sckM;
    n.sck3 = q.sck2;
    n.siM  = si;
    n.si2  = q.siM;
    n.wpM  = wpN;
    n.wp2  = q.wpM;
    if (q.pushValid && pushIf.ready)
      n.pushValid = 1'b0;
    if (!csLow)
    begin
      // Frame over: a half byte never reaches the array
      n.state = S_IDLE;
      n.soOe  = 1'b0;
      n.so    = 1'b0;
      if (csRise && q.pendClr)
        n.write_enable_latch = 1'b0;
      n.pendClr = 1'b0;
    end
    else if (csFall)
    begin
      n.state   = S_OPCODE;
      n.bitCnt  = 3'h0;
      n.stopped = 1'b0;
    end
    else
    begin
      if (sckRise && (q.state != S_STRD) && (q.state != S_SKIP) && (q.state != S_IDLE))
      begin
        n.inSh   = inByte;
        n.bitCnt = q.bitCnt + 3'h1;
      end
      if (byteDone)
      begin
        unique case (q.state)
          S_OPCODE:
          begin
            n.bitCnt = 3'h0;
            if (inByte == OP_SET_LATCH)
            begin
              n.write_enable_latch   = 1'b1;
              n.state = S_SKIP;
            end
            else if (inByte == OP_CLEAR_LATCH)
            begin
              n.pendClr = 1'b1;
              n.state   = S_SKIP;
            end
            else if (inByte == OP_STATUS_RD)
              n.state = S_STRD;
            else if (inByte == OP_STATUS_WR)
            begin
              n.pendClr = 1'b1;
              n.state   = S_STWR;
            end
            else if (isWriteOp(inByte))
            begin
              n.addr[8] = inByte[OP_A8_POS];
              n.pendClr = 1'b1;
              n.state   = S_ADDR;
            end
            else
              n.state = S_SKIP;
          end
          S_ADDR:
          begin
            n.addr  = {q.addr[8], inByte};
            n.state = S_WDATA;
          end
          S_WDATA:
          begin
            if (isGuarded(q.bp, q.addr))
              n.stopped = 1'b1;
            else if (q.stopped || !q.write_enable_latch || !wpHigh || q.pushValid)
              n.stopped = q.stopped;
            else
            begin
              // Committed as soon as the eighth bit lands
              n.pushValid = 1'b1;
              n.pushAddr  = q.addr;
              n.pushData  = inByte;
              n.addr      = q.addr + 9'h001;
            end
          end
          S_STWR:
          begin
            // The latch flag in the written byte is ignored on purpose
            if (q.write_enable_latch && wpHigh)
              n.bp = inByte[SR_GUARD_HI:SR_GUARD_LO];
            n.state = S_SKIP;
          end
          default:
            n.state = q.state;
        endcase
      end
      if (sckFall && (q.state == S_STRD))
      begin
        // Status repeats every eight clocks while the frame lasts
        n.soOe   = 1'b1;
        n.so     = txBits[7];
        n.outSh  = {txBits[6:0], 1'b0};
        n.bitCnt = q.bitCnt + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      q       <= '0;
      q.csM   <= 1'b1;
      q.cs2   <= 1'b1;
      q.cs3   <= 1'b1;
      q.state <= S_IDLE;
      q.write_enable_latch   <= LATCH_RESET;
      q.bp    <= GUARD_RESET;
    end
    else
      q <= n;
  end

  assign pushIf.valid = q.pushValid;
  assign pushIf.addr  = q.pushAddr;
  assign pushIf.data  = q.pushData;
  assign so           = q.so;
  assign soOe         = q.soOe;
  assign latchOn      = q.write_enable_latch;
  assign guardBits    = q.bp;

  // ==========================================================
  // Write path
  wr_buffer wrBuf
  (
    .mclk  (mclk),
    .rst   (rst),
    .fill  (pushIf.snk),
    .drain (memIf.src)
  );

  fram_array mem
  (
    .mclk   (mclk),
    .wr     (memIf.snk),
    .rdAddr (memRdAddr),
    .rdData (memRdData)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Reset itself must be watched, so the default disable is overridden here
  latch_after_reset_a: assert property (disable iff (1'b0) rst |=> !q.write_enable_latch)
    else $error("latch not clear after reset");
  latch_set_a: assert property (q.state == S_OPCODE && byteDone && inFrame
      && inByte == OP_SET_LATCH |=> q.write_enable_latch)
    else $error("set-latch did not set latch");
  latch_rise_src_a: assert property ($rose(q.write_enable_latch) |-> $past(q.state) == S_OPCODE)
    else $error("latch set by something other than set-latch");
  latch_hold_a: assert property (q.state == S_STWR && inFrame
      |=> q.write_enable_latch == $past(q.write_enable_latch))
    else $error("status write changed the latch");
  latch_clear_a: assert property (!csLow && csRise && q.pendClr |=> !q.write_enable_latch)
    else $error("latch not cleared at chip-select rise");
  status_fixed_a: assert property (q.soOe |-> q.state == S_STRD)
    else $error("output driven outside status read");
  push_allowed_a: assert property ($rose(q.pushValid) |-> $past(q.write_enable_latch) && $past(wpHigh)
      && $past(csLow))
    else $error("write committed without latch or pin");
  push_unguarded_a: assert property ($rose(q.pushValid) |->
      !isGuarded(q.bp, q.pushAddr))
    else $error("write committed to guarded block");
  addr_step_a: assert property ($rose(q.pushValid) |-> q.addr == q.pushAddr + 9'h001)
    else $error("address did not step after commit");
  guard_change_a: assert property ($changed(q.bp) |-> $past(q.write_enable_latch) && $past(wpHigh)
      && $past(q.state) == S_STWR)
    else $error("guard bits changed without permission");
  wp_block_a: assert property (!wpHigh |=> !$rose(q.pushValid) && $stable(q.bp))
    else $error("write accepted with protect pin low");
  idle_quiet_a: assert property (!csLow |=> !q.soOe)
    else $error("output left on after frame end");
  cut_frame_a: assert property (!csLow |=> !$rose(q.pushValid))
    else $error("byte committed after chip-select rise");
  commit_now_a: assert property (q.state == S_WDATA && byteDone && inFrame && q.write_enable_latch
      && wpHigh && !q.stopped && !isGuarded(q.bp, q.addr)
      |=> q.pushValid && q.pushData == $past(inByte))
    else $error("byte not committed at its eighth bit");
  guard_stop_a: assert property (q.stopped && inFrame
      |=> $stable(q.addr) && !$rose(q.pushValid))
    else $error("burst went on past a guarded address");

  // ==========================================================
  // Serial decode and status output checks
  one_opcode_a: assert property (q.state != S_IDLE && q.state != S_OPCODE && !csFall
      |=> q.state != S_OPCODE)
    else $error("second opcode taken in one frame");
  skip_quiet_a: assert property (q.state == S_SKIP
      |=> !$rose(q.pushValid) && !q.soOe)
    else $error("ignored frame had an effect");
  msb_first_a: assert property (sckRise && inFrame && q.state != S_IDLE
      && q.state != S_STRD && q.state != S_SKIP |=> q.inSh == {$past(q.inSh[6:0]), $past(q.si2)})
    else $error("input bit not shifted in at the low end");
  addr_hi_a: assert property (q.state == S_OPCODE && byteDone && inFrame
      && isWriteOp(inByte) |=> q.addr[8] == $past(inByte[OP_A8_POS]))
    else $error("upper address bit not taken from opcode");
  status_start_a: assert property (q.state == S_STRD && sckFall && inFrame
      |=> q.soOe)
    else $error("status output not driven after serial clock fall");
  status_zero_a: assert property (q.state == S_STRD && sckFall && inFrame
      && (q.bitCnt <= 3'h3 || q.bitCnt == 3'h7) |=> !q.so)
    else $error("fixed status bit read as one");
  status_latch_a: assert property (q.state == S_STRD && sckFall && inFrame
      && q.bitCnt == 3'h6 |=> q.so == $past(q.write_enable_latch))
    else $error("status latch bit wrong");
  status_guard_a: assert property (q.state == S_STRD && sckFall && inFrame
      && q.bitCnt == 3'h4 |=> q.so == $past(q.bp[1]))
    else $error("status guard bit wrong");

  set_cmd_c: cover property ($rose(q.write_enable_latch));
  mem_push_c: cover property ($rose(q.pushValid) ##[1:400] $rose(q.pushValid));
  guard_stop_c: cover property ($rose(q.stopped));
  status_write_c: cover property ($changed(q.bp));
  status_read_c: cover property ($rose(q.soOe));
endmodule

// [spi_master_model.sv]
`timescale 1ns/10ps
module spi_master_model
(
  // Clock
  input  wire logic mclk,
  // Serial pins
  output logic      csN,
  output logic      sck,
  output logic      si,
  input  wire logic so,
  input  wire logic soOe
);
  // ============
  // Idle levels, mode 0
  initial
  begin
    csN = 1'b1;
    sck = 1'b0;
    si  = 1'b0;
  end

  // ============
  // Frame control
  task automatic frame_start();
    @(negedge mclk);
    csN = 1'b0;
    repeat (4) @(negedge mclk);
  endtask

  // Gap of 8 cycles covers the slave's chip-select resync
  task automatic frame_end();
    @(negedge mclk);
    csN = 1'b1;
    si  = ~si;
    repeat (8) @(negedge mclk);
  endtask

  // Offset of 1 ns keeps serial edges off every mclk edge
  task automatic xfer(input logic [7:0] tx, input int nBits, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge mclk);
    #1;
    for (int i = 7; i > 7 - nBits; i--)
    begin
      si = tx[i];
      #62.5 sck = 1'b1;
      rx[i] = soOe ? so : 1'bx;
      #62.5 sck = 1'b0;
    end
  endtask
endmodule

// [spi_fram_write_guard_test.sv]
`timescale 1ns/10ps
module spi_fram_write_guard_test;
  import fram_guard_pkg::*;
  logic              mclk;
  logic              rst;
  logic              csN;
  logic              sck;
  logic              si;
  logic              wpN;
  logic              so;
  logic              soOe;
  logic              latchOn;
  logic              oeSeen;
  logic [1:0]        guardBits;
  logic [ADDR_W-1:0] memRdAddr;
  logic [DATA_W-1:0] memRdData;
  logic [7:0]        rd;
  int                err_total;
  int                total_checks;
  int                cycles;

  spi_fram_write_guard i_dut (.mclk(mclk), .rst(rst), .csN(csN), .sck(sck), .si(si),
    .wpN(wpN), .so(so), .soOe(soOe), .latchOn(latchOn), .guardBits(guardBits),
    .memRdAddr(memRdAddr), .memRdData(memRdData));
  spi_master_model i_master (.mclk(mclk), .csN(csN), .sck(sck), .si(si), .so(so),
    .soOe(soOe));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ============
  // Watchdog and output-enable monitor
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (soOe === 1'b1)
      oeSeen <= 1'b1;
    if (cycles == 60000)
    begin
      err_total++;
      print_verdict();
    end
  end

  // ============
  // Helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic frame2(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    i_master.frame_start();
    i_master.xfer(a, 8, d);
    i_master.xfer(b, 8, rd);
    i_master.frame_end();
  endtask

  task automatic cmd(input logic [7:0] op);
    logic [7:0] d;
    i_master.frame_start();
    i_master.xfer(op, 8, d);
    i_master.frame_end();
  endtask

  task automatic stat_wr(input logic [7:0] v);
    cmd(OP_SET_LATCH);
    frame2(OP_STATUS_WR, v);
  endtask

  // Data is left aligned; partBits > 0 adds one more byte of ones, cut short after partBits bits
  task automatic mem_wr(input logic [8:0] a, input logic [31:0] dat, input int n,
                        input int partBits);
    logic [7:0] d;
    cmd(OP_SET_LATCH);
    i_master.frame_start();
    i_master.xfer({4'h0, a[8], OP_WRITE_LOW}, 8, d);
    i_master.xfer(a[7:0], 8, d);
    for (int i = 0; i < n; i++)
      i_master.xfer(dat[31-8*i -: 8], 8, d);
    if (partBits > 0)
      i_master.xfer(8'hff, partBits, d);
    i_master.frame_end();
  endtask

  task automatic mem_chk(input logic [8:0] a, input logic [7:0] exp);
    @(negedge mclk);
    memRdAddr = a;
    repeat (2) @(negedge mclk);
    check(memRdData, exp);
  endtask

  // ============
  // Scenarios
  task automatic test_latch();
    check({7'h00, latchOn}, 8'h00);
    frame2(OP_STATUS_RD, 8'h00);
    check(rd, 8'h00);
    cmd(OP_SET_LATCH);
    check({7'h00, latchOn}, 8'h01);
    frame2(OP_STATUS_RD, 8'h00);
    check(rd, 8'h02);
    cmd(OP_CLEAR_LATCH);
    frame2(OP_STATUS_RD, 8'h00);
    check(rd, 8'h00);
    $display("test latch done");
  endtask

  task automatic test_status();
    stat_wr(8'hff);
    frame2(OP_STATUS_RD, 8'h00);
    check(rd, 8'h0c);
    check({6'h00, guardBits}, 8'h03);
    frame2(OP_STATUS_WR, 8'h00);
    check({6'h00, guardBits}, 8'h03);
    stat_wr(8'h00);
    check({6'h00, guardBits}, 8'h00);
    $display("test status done");
  endtask

  task automatic test_burst();
    mem_wr(9'h000, 32'ha53c0f00, 3, 0);
    mem_wr(9'h1fe, 32'h8142c300, 3, 5);
    check({7'h00, latchOn}, 8'h00);
    mem_chk(9'h1fe, 8'h81);
    mem_chk(9'h1ff, 8'h42);
    mem_chk(9'h000, 8'hc3);
    mem_chk(9'h001, 8'h3c);
    cmd(OP_SET_LATCH);
    cmd(OP_CLEAR_LATCH);
    i_master.frame_start();
    i_master.xfer(8'h02, 8, rd);
    i_master.xfer(8'h02, 8, rd);
    i_master.xfer(8'h99, 8, rd);
    i_master.frame_end();
    mem_chk(9'h002, 8'h0f);
    $display("test burst done");
  endtask

  task automatic test_guard();
    logic [8:0] b;
    for (int g = 1; g < 3; g++)
    begin
      b = (g == 1) ? 9'h180 : 9'h100;
      mem_wr(b - 9'h001, 32'h0, 2, 0);
      stat_wr({4'h0, g[1:0], 2'h0});
      mem_wr(b - 9'h001, 32'h5aa57700, 3, 0);
      mem_chk(b - 9'h001, 8'h5a);
      mem_chk(b, 8'h00);
      mem_wr(b, 32'h66000000, 1, 0);
      mem_chk(b, 8'h00);
    end
    stat_wr(8'h0c);
    mem_wr(9'h001, 32'h77000000, 1, 0);
    mem_chk(9'h001, 8'h3c);
    stat_wr(8'h00);
    $display("test guard done");
  endtask

  task automatic test_wp();
    @(negedge mclk);
    wpN = 1'b0;
    stat_wr(8'h0c);
    check({6'h00, guardBits}, 8'h00);
    mem_wr(9'h002, 32'he7000000, 1, 0);
    mem_chk(9'h002, 8'h0f);
    @(negedge mclk);
    wpN = 1'b1;
    $display("test wp done");
  endtask

  task automatic test_opcode();
    oeSeen = 1'b0;
    frame2(8'hff, OP_SET_LATCH);
    check({7'h00, latchOn}, 8'h00);
    check({7'h00, oeSeen}, 8'h00);
    frame2(8'h0b, OP_SET_LATCH);
    check({7'h00, latchOn}, 8'h00);
    check({7'h00, oeSeen}, 8'h00);
    frame2(OP_STATUS_RD, OP_SET_LATCH);
    check({7'h00, latchOn}, 8'h00);
    check(rd, 8'h00);
    $display("test opcode done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    wpN = 1'b1;
    memRdAddr = '0;
    oeSeen = 1'b0;
    err_total = 0;
    total_checks = 0;
    cycles = 0;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    test_latch();
    test_status();
    test_burst();
    test_guard();
    test_wp();
    test_opcode();
    print_verdict();
  end
endmodule
